// File: logic/i2c_slave_tx_core.sv
// I2C responder transmitter with end states, bus error handling and AXI4-Lite registers
module i2c_slave_tx_core
    import i2c_slave_pkg::*;
#(
    parameter int HOLD_CYC = START_HOLD_CYC
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    i2c_line_if line ();

    i2c_line_monitor u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line)
    );

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_SETUP || a == ADDR_CODE || a == ADDR_BYTE || a == ADDR_OWN
            || a == ADDR_IRQ_STAT || a == ADDR_IRQ_MASK;
    endfunction

    // Register state
    logic acknowledge_enable;
    logic halt_condition_request;
    logic begin_condition_request;
    logic si;
    logic [7:0] code;
    logic [7:0] byte_buffer;
    logic [7:0] target_id;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // Core state
    core_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic gc_hit;
    logic last_byte;
    logic ending;
    logic ack_seen;
    logic [15:0] hold_cnt;
    logic si_set;
    logic err_set;
    logic start_taken;

    // AXI write channel capture
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic wr_fire;
    logic wr_setup;
    logic si_clear;
    logic halt_eff;
    logic rd_fire;

    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign wr_setup = wr_fire && waddr == ADDR_SETUP && wlane;
    assign si_clear = wr_setup && wbyte[BIT_SI] && si;
    assign halt_eff = wbyte[BIT_HALT];
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            waddr <= '0;
            wbyte <= '0;
            wlane <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_full <= 1'b1;
                    waddr <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_full <= 1'b1;
                    wbyte <= s_axi_wdata[7:0];
                    wlane <= s_axi_wstrb[0];
                end
            end
            // One write at a time: channels reopen once the response is gone
            s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_full && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(waddr) ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
                s_axi_rdata <= '0;
                case (s_axi_araddr)
                    ADDR_SETUP: begin
                        s_axi_rdata[BIT_ACK] <= acknowledge_enable;
                        s_axi_rdata[BIT_SI] <= si;
                        s_axi_rdata[BIT_HALT] <= halt_condition_request;
                        s_axi_rdata[BIT_BEGIN] <= begin_condition_request;
                    end
                    ADDR_CODE: s_axi_rdata[7:0] <= si ? code : CODE_NONE;
                    ADDR_BYTE: s_axi_rdata[7:0] <= byte_buffer;
                    ADDR_OWN: s_axi_rdata[7:0] <= target_id;
                    ADDR_IRQ_STAT: s_axi_rdata[IRQ_W-1:0] <= irq_status;
                    ADDR_IRQ_MASK: s_axi_rdata[IRQ_W-1:0] <= irq_mask;
                    default: s_axi_rdata <= '0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Setup flags: hardware clears of halt and begin win over the same write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acknowledge_enable <= 1'b0;
            halt_condition_request <= 1'b0;
            begin_condition_request <= 1'b0;
        end else begin
            if (wr_setup) begin
                acknowledge_enable <= wbyte[BIT_ACK];
                halt_condition_request <= wbyte[BIT_HALT];
                begin_condition_request <= wbyte[BIT_BEGIN];
            end
            if (si_clear && halt_eff) begin
                halt_condition_request <= 1'b0;
            end
            if (start_taken) begin
                begin_condition_request <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_buffer <= '0;
            target_id <= OWN_RESET;
            irq_mask <= '0;
        end else if (wr_fire && wlane) begin
            if (waddr == ADDR_BYTE) begin
                byte_buffer <= wbyte;
            end
            if (waddr == ADDR_OWN) begin
                target_id <= wbyte;
            end
            if (waddr == ADDR_IRQ_MASK) begin
                irq_mask <= wbyte[IRQ_W-1:0];
            end
        end
    end

    // Flag is write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            si <= 1'b0;
        end else if (si_set) begin
            si <= 1'b1;
        end else if (si_clear) begin
            si <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (rd_fire && s_axi_araddr == ADDR_IRQ_STAT) ? '0 : irq_status;
            if (si_set) begin
                irq_status[IRQ_SI] <= 1'b1;
            end
            if (err_set) begin
                irq_status[IRQ_ERR] <= 1'b1;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // Byte-level state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= st_idle;
            bit_cnt <= '0;
            shift <= '0;
            gc_hit <= 1'b0;
            last_byte <= 1'b0;
            ending <= 1'b0;
            ack_seen <= 1'b0;
            hold_cnt <= '0;
            code <= CODE_NONE;
            si_set <= 1'b0;
            err_set <= 1'b0;
            start_taken <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            si_set <= 1'b0;
            err_set <= 1'b0;
            start_taken <= 1'b0;
            if (si_clear && halt_eff) begin
                // Plain release, no STOP driven
                state <= st_idle;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
            end else if ((line.start_seen || line.stop_seen) && state != st_idle
                    && state != st_addr && state != st_start) begin
                // Only reached as master or addressed responder
                state <= st_idle;
                code <= CODE_BUS_ERR;
                si_set <= 1'b1;
                err_set <= 1'b1;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
            end else begin
                case (state)
                    st_idle: begin
                        sda_oe <= 1'b0;
                        if (line.start_seen) begin
                            state <= st_addr;
                            bit_cnt <= '0;
                        end else if (begin_condition_request && line.bus_free && !si) begin
                            state <= st_start;
                            hold_cnt <= '0;
                            sda_oe <= 1'b1;
                        end
                    end
                    st_addr: begin
                        if (line.start_seen) begin
                            bit_cnt <= '0;
                        end else if (line.stop_seen) begin
                            state <= st_idle;
                        end else if (line.scl_rise) begin
                            shift <= {shift[6:0], line.sda};
                            bit_cnt <= bit_cnt + 4'd1;
                        end else if (line.scl_fall && bit_cnt == BITS_PER_BYTE) begin
                            // Recognition needs acknowledge enable set
                            if (acknowledge_enable && shift[7:1] == target_id[7:1]
                                    && shift[0]) begin
                                state <= st_addr_ack;
                                gc_hit <= 1'b0;
                                sda_oe <= 1'b1;
                            end else if (acknowledge_enable && target_id[0]
                                    && shift == GC_ADDR) begin
                                state <= st_addr_ack;
                                gc_hit <= 1'b1;
                                sda_oe <= 1'b1;
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    st_addr_ack: begin
                        if (line.scl_fall) begin
                            sda_oe <= 1'b0;
                            scl_oe <= 1'b1;
                            si_set <= 1'b1;
                            code <= gc_hit ? CODE_GC : CODE_OWN_READ;
                            // General call data is not received here; it ends the frame
                            ending <= gc_hit;
                            state <= st_hold;
                        end
                    end
                    st_hold: begin
                        if (si_clear) begin
                            if (ending) begin
                                // Not addressed; later clocks see released SDA
                                state <= st_idle;
                                scl_oe <= 1'b0;
                            end else begin
                                shift <= byte_buffer;
                                last_byte <= !wbyte[BIT_ACK];
                                sda_oe <= !byte_buffer[7];
                                bit_cnt <= '0;
                                scl_oe <= 1'b0;
                                state <= st_tx;
                            end
                        end
                    end
                    st_tx: begin
                        if (line.scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE - 4'd1) begin
                                sda_oe <= 1'b0;
                                state <= st_tx_ack;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe <= !shift[6];
                                bit_cnt <= bit_cnt + 4'd1;
                            end
                        end
                    end
                    st_tx_ack: begin
                        if (line.scl_rise) begin
                            ack_seen <= !line.sda;
                        end else if (line.scl_fall) begin
                            scl_oe <= 1'b1;
                            si_set <= 1'b1;
                            state <= st_hold;
                            if (!ack_seen) begin
                                code <= CODE_TX_NACK;
                                ending <= 1'b1;
                            end else if (last_byte) begin
                                code <= CODE_LAST_ACK;
                                ending <= 1'b1;
                            end else begin
                                code <= CODE_TX_ACK;
                                ending <= 1'b0;
                            end
                        end
                    end
                    st_start: begin
                        // SDA held low for the START hold time, then SCL pulled low
                        if (hold_cnt == 16'(HOLD_CYC - 1)) begin
                            scl_oe <= 1'b1;
                            si_set <= 1'b1;
                            start_taken <= 1'b1;
                            code <= CODE_START;
                            ending <= 1'b1;
                            state <= st_hold;
                        end else begin
                            hold_cnt <= hold_cnt + 16'd1;
                        end
                    end
                    default: begin
                        state <= st_idle;
                        code <= CODE_BUS_ERR;
                        si_set <= 1'b1;
                        err_set <= 1'b1;
                        sda_oe <= 1'b0;
                        scl_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain: value is always low, the enable decides
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end
endmodule

// File: logic/i2c_slave_pkg.sv
// Constants, codes and state encoding of the I2C responder transmit core
package i2c_slave_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int START_HOLD_NS = 4000;
    localparam int START_HOLD_CYC = (START_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_SETUP = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CODE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_BYTE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_OWN = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h14;
    localparam int BIT_ACK = 2;
    localparam int BIT_SI = 3;
    localparam int BIT_HALT = 4;
    localparam int BIT_BEGIN = 5;
    localparam int IRQ_SI = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_W = 2;
    localparam logic [7:0] CODE_NONE = 8'hf8;
    localparam logic [7:0] CODE_BUS_ERR = 8'h00;
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_GC = 8'h70;
    localparam logic [7:0] CODE_OWN_READ = 8'ha8;
    localparam logic [7:0] CODE_TX_ACK = 8'hb8;
    localparam logic [7:0] CODE_TX_NACK = 8'hc0;
    localparam logic [7:0] CODE_LAST_ACK = 8'hc8;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] OWN_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'd8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;
    typedef enum logic [3:0] {
        st_idle = 4'b0000,
        st_addr = 4'b0001,
        st_addr_ack = 4'b0010,
        st_hold = 4'b0011,
        st_tx = 4'b0100,
        st_tx_ack = 4'b0101,
        st_start = 4'b0110
    } core_state_t;
endpackage

// File: logic/i2c_line_if.sv
// Synchronised bus line events passed from the line monitor to the core
interface i2c_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic bus_free;
    modport mon (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen, bus_free);
    modport core (input scl, sda, scl_rise, scl_fall, start_seen, stop_seen, bus_free);
endinterface

// File: logic/i2c_line_monitor.sv
// Pin synchroniser and START/STOP/edge detector for SCL and SDA
module i2c_line_monitor
    import i2c_slave_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic scl_i,
    input wire logic sda_i,
    i2c_line_if.mon line
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;

    // Stage 0 feeds only stage 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line.scl <= 1'b1;
            line.sda <= 1'b1;
            line.scl_rise <= 1'b0;
            line.scl_fall <= 1'b0;
            line.start_seen <= 1'b0;
            line.stop_seen <= 1'b0;
        end else begin
            line.scl <= scl_sync[1];
            line.sda <= sda_sync[1];
            line.scl_rise <= scl_sync[1] && !scl_q;
            line.scl_fall <= !scl_sync[1] && scl_q;
            line.start_seen <= scl_sync[1] && scl_q && sda_q && !sda_sync[1];
            line.stop_seen <= scl_sync[1] && scl_q && !sda_q && sda_sync[1];
        end
    end

    // Bus counts as free from reset until a START, then again after STOP
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line.bus_free <= 1'b1;
        end else if (scl_sync[1] && scl_q && sda_q && !sda_sync[1]) begin
            line.bus_free <= 1'b0;
        end else if (scl_sync[1] && scl_q && !sda_q && sda_sync[1]) begin
            line.bus_free <= 1'b1;
        end
    end
endmodule

// File: sim/i2c_slave_tx_core_asserts.sv
// Port-level checker for the I2C responder transmit core
module i2c_slave_tx_core_asserts
    import i2c_slave_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire w_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire r_hs = s_axi_arvalid && s_axi_arready;
    wire w_bad = s_axi_awaddr > ADDR_IRQ_MASK;
    wire r_bad = s_axi_araddr > ADDR_IRQ_MASK;
    wire halt_wr = w_hs && s_axi_awaddr == ADDR_SETUP && s_axi_wdata[BIT_HALT];
    property p_wresp;
        w_hs |=> ##1 s_axi_bvalid && s_axi_bresp == ($past(w_bad, 2) ? RESP_DECERR : RESP_OKAY);
    endproperty
    a_wresp: assert property (p_wresp) else $error("write response wrong");
    property p_rresp;
        r_hs |=> s_axi_rvalid && ($past(r_bad) ? s_axi_rresp == RESP_DECERR
            && s_axi_rdata == 32'h0 : s_axi_rresp == RESP_OKAY);
    endproperty
    a_rresp: assert property (p_rresp) else $error("read response wrong");
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("bvalid stayed");
    property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdrop: assert property (p_rdrop) else $error("rvalid stayed");
    property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wblock: assert property (p_wblock) else $error("write taken during response");
    property p_rblock; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rblock: assert property (p_rblock) else $error("read taken during response");
    property p_recover; halt_wr |=> ##[0:3] !scl_oe && !sda_oe; endproperty
    a_recover: assert property (p_recover) else $error("lines kept");
    property p_hold_irq; $rose(scl_oe) |-> ##[0:4] irq; endproperty
    a_hold_irq: assert property (p_hold_irq) else $error("clock held w/o flag");
    c_irq: cover property ($rose(irq));
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
    c_release: cover property ($fell(scl_oe));
endmodule

bind i2c_slave_tx_core i2c_slave_tx_core_asserts chk (.*);

// File: sim/i2c_master_model.sv
// Behavioural I2C bus master acting as receiver, honours clock stretching
module i2c_master_model (
    input wire logic aclk,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_rel,
    output logic sda_rel
);
    timeunit 1ns;
    timeprecision 1ns;
    int stalls = 0;
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    // Bit cell of 8 aclk (400 ns); data only moves while SCL is low
    task automatic bitx(input logic b, output logic r);
        int i;
        repeat (2) @(posedge aclk);
        sda_rel <= b;
        repeat (3) @(posedge aclk);
        scl_rel <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 4000 && scl_line !== 1'b1; i++) @(posedge aclk);
        if (i == 4000) stalls++;
        r = sda_line;
        repeat (2) @(posedge aclk);
        scl_rel <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ab, ack);
    endtask
    // s=1 gives START (SCL left low), s=0 gives STOP
    task automatic cond(input logic s);
        repeat (2) @(posedge aclk);
        sda_rel <= s;
        repeat (3) @(posedge aclk);
        scl_rel <= 1'b1;
        repeat (4) @(posedge aclk);
        sda_rel <= !s;
        repeat (4) @(posedge aclk);
        if (s) scl_rel <= 1'b0;
    endtask
endmodule

// File: sim/i2c_slave_tx_core_tb_top.sv
// Bench top: register sequences against a behavioural I2C master
module i2c_slave_tx_core_tb_top
    import i2c_slave_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, q;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, ack;
    int error_cnt = 0;
    int n_compared = 0;
    wire scl_w = (scl_oe ? scl_o : 1'b1) & m_scl;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & m_sda;
    always #25 aclk = ~aclk;
    i2c_slave_tx_core #(.HOLD_CYC(4)) uut (.*, .scl_i(scl_w), .sda_i(sda_w));
    i2c_master_model m (.aclk(aclk), .scl_line(scl_w), .sda_line(sda_w), .scl_rel(m_scl),
        .sda_rel(m_sda));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic hang();
        chk("wait", 1, 0);
        print_verdict();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (i == 50) hang();
        s_axi_bready <= 1'b0;
        chk("bresp", a > ADDR_IRQ_MASK ? RESP_DECERR : RESP_OKAY, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (i = 0; i < 50 && !s_axi_rvalid; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (i == 50) hang();
        s_axi_rready <= 1'b0;
        chk("rresp", a > ADDR_IRQ_MASK ? RESP_DECERR : RESP_OKAY, s_axi_rresp);
        chk("rdata", e, s_axi_rdata & msk);
    endtask
    task automatic wirq();
        int i;
        for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
        if (i == 3000) hang();
    endtask
    task automatic to_last();
        m.cond(1'b1);
        m.xfer(8'h55, 1'b1, q, ack);
        chk("addr ack", 0, ack);
        wirq();
        chk("scl held", 1, scl_oe);
        rd(ADDR_IRQ_STAT, 1, 1);
        rd(ADDR_CODE, CODE_OWN_READ, 8'hff);
        wr(ADDR_BYTE, 8'ha5);
        wr(ADDR_SETUP, 8'h08);
        rd(ADDR_CODE, CODE_NONE, 8'hff);
        m.xfer(8'hff, 1'b0, q, ack);
        chk("data", 8'ha5, q);
        wirq();
        rd(ADDR_CODE, CODE_LAST_ACK, 8'hff);
        rd(ADDR_IRQ_STAT, 1, 1);
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Lane 0 strobe off: the write must leave the id alone
        wr(ADDR_OWN, 8'h33);
        s_axi_wstrb <= 4'h1;
        rd(ADDR_OWN, OWN_RESET, 8'hff);
        rd(ADDR_CODE, CODE_NONE, 8'hff);
        rd(8'h20, 0, 32'hffffffff);
        wr(8'h20, 8'h00);
        wr(ADDR_OWN, 8'h55);
        wr(ADDR_IRQ_MASK, 8'h03);
        $display("idle test done");
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_SETUP, 8'h04);
            to_last();
            wr(ADDR_SETUP, 8'h08 | (k == 1 ? 8'h04 : 8'h00) | (k == 2 ? 8'h20 : 8'h00));
            m.xfer(8'hff, 1'b1, q, ack);
            chk("after last", 8'hff, q);
            m.cond(1'b0);
            if (k == 2) begin
                wirq();
                rd(ADDR_CODE, CODE_START, 8'hff);
                wr(ADDR_SETUP, 8'h08);
            end
            m.cond(1'b1);
            m.xfer(k == 0 ? GC_ADDR : 8'h55, 1'b1, q, ack);
            chk("readdress ack", k != 1, ack);
            if (k == 1) begin
                wirq();
                rd(ADDR_IRQ_STAT, 1, 1);
                wr(ADDR_BYTE, 8'hff);
                wr(ADDR_SETUP, 8'h0c);
                repeat (3) m.bitx(1'b1, ack);
                m.cond(1'b1);
                wirq();
                rd(ADDR_CODE, CODE_BUS_ERR, 8'hff);
                chk("lines", 0, {scl_oe, sda_oe});
                wr(ADDR_IRQ_MASK, 8'h00);
                repeat (3) @(posedge aclk);
                chk("irq masked", 0, irq);
                wr(ADDR_IRQ_MASK, 8'h03);
                rd(ADDR_IRQ_STAT, 2, 2);
                repeat (3) @(posedge aclk);
                chk("irq cleared", 0, irq);
                wr(ADDR_SETUP, 8'h1c);
                rd(ADDR_SETUP, 8'h04, 8'h3c);
            end
            m.cond(1'b0);
            rd(ADDR_CODE, CODE_NONE, 8'hff);
            $display("exit mode %0d test done", k);
        end
        chk("stalls", 0, m.stalls);
        print_verdict();
    end
endmodule
